// *** core/channel_gate_trigger_regs.svh ***
// Register indices, field positions and mode codes of the gate trigger.
`ifndef CHANNEL_GATE_TRIGGER_REGS_SVH
`define CHANNEL_GATE_TRIGGER_REGS_SVH

`define IDX_OR_MASK        30'h0000_9E0C
`define IDX_MODE           30'h0000_9EA2
`define IDX_LEVEL          30'h0000_A4D8
`define IDX_SECOND_LEVEL   30'h0000_A53C
`define IDX_CONTROL        30'h0000_9F00
`define IDX_STATUS         30'h0000_9F01

`define MASK_CH0_BIT       0
`define CTRL_RUN_BIT       0
`define STAT_GATE_BIT      0
`define STAT_ARMED_BIT     1
`define STAT_RUN_BIT       2

`define MODE_RISING_EDGE   32'h0000_0001
`define MODE_FALLING_EDGE  32'h0000_0002
`define MODE_HIGH_LEVEL    32'h0000_0008
`define MODE_LOW_LEVEL     32'h0000_0010
`define MODE_REARM_FLAG    32'h0100_0000
`define MODE_REARM_NEG_ALT 32'h0010_0002

`define RESET_WORD         32'h0000_0000
`define HSIZE_WORD         3'h2

`endif

// *** core/channel_gate_trigger_pkg.sv ***
// Types shared by the channel gate trigger.
package channel_gate_trigger_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FIRST = 3'b010,
    ST_RUN   = 3'b100
  } acq_t;

  typedef struct packed {
    word_t       or_mask;
    word_t       mode;
    word_t       lvl0;
    word_t       lvl1;
    logic        run;
    word_t       sh_mode;
    word_t       sh_lvl0;
    word_t       sh_lvl1;
    logic        sh_en;
    acq_t        acq;
    logic        prev_trig_hi;
    logic        prev_arm_hi;
    logic        gate;
    logic        armed;
    logic        wr_pend;
    logic [29:0] wr_idx;
    word_t       hrdata;
    logic        hreadyout;
    logic        hresp;
  } state_t;

endpackage : channel_gate_trigger_pkg

// *** core/channel_gate_trigger.sv ***
// Channel gate trigger engine with its AHB-Lite register slave.
`timescale 1ns/1ps
`include "channel_gate_trigger_regs.svh"

// Operation
// - Channel affects gate only when mask bit set.
// - Every sample is evaluated while running.
// - Rising edge mode opens on upward crossing.
// - Rising edge mode closes on downward crossing.
// - Edge modes ignore level present at start.
// - High level mode: open while at/above level.
// - Level modes open at start if qualifying.
// - Falling edge: open down, close up crossing.
// - Low level mode: open while at/below level.
// - Re-arm rising arms on upward re-arm crossing.
// - Armed upward crossing opens gate, disarms unless re-arm also crosses up.
// - Re-arm rising closes on downward crossing.
// - Disarmed engine ignores opening trigger crossings.
// - Re-arm falling arms on downward re-arm crossing.
// - Armed downward crossing opens; upward closes.
module channel_gate_trigger #(
  parameter int DATA_W = 16
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          hsel,
  input  wire channel_gate_trigger_pkg::word_t haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire channel_gate_trigger_pkg::word_t hwdata,
  input  wire logic                          hready,
  output channel_gate_trigger_pkg::word_t    hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic [DATA_W-1:0]             sample,
  input  wire logic                          sample_valid,
  output logic                               gate,
  output logic                               armed
);
  import channel_gate_trigger_pkg::*;

  if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
    $error("DATA_W must lie between 2 and 32.");
  end

  state_t q;
  state_t d;

  // Reset leaves the engine idle with every register cleared.
  localparam state_t RESET_STATE = '{acq: ST_IDLE, default: '0};

  logic acc;
  logic trig_hi;
  logic trig_le;
  logic arm_hi;
  logic up_trig;
  logic dn_trig;
  logic up_arm;
  logic dn_arm;
  logic m_pos;
  logic m_neg;
  logic m_high;
  logic m_low;
  logic m_rpos;
  logic m_rneg;
  logic running;

  // Builds the read answer for one register index.
  function automatic word_t read_word(input state_t s,
                                      input logic [29:0] idx);
    word_t w;
    w = `RESET_WORD;
    case (idx)
      `IDX_OR_MASK:      w = s.or_mask;
      `IDX_MODE:         w = s.mode;
      `IDX_LEVEL:        w = s.lvl0;
      `IDX_SECOND_LEVEL: w = s.lvl1;
      `IDX_CONTROL:      w[`CTRL_RUN_BIT] = s.run;
      `IDX_STATUS: begin
        w[`STAT_GATE_BIT]  = s.gate;
        w[`STAT_ARMED_BIT] = s.armed;
        w[`STAT_RUN_BIT]   = (s.acq != ST_IDLE);
      end
      default: w = `RESET_WORD;
    endcase
    return w;
  endfunction : read_word

  assign acc = hsel && htrans[1] && hready && (hsize == `HSIZE_WORD);

  // Sample relations to the latched levels.
  assign trig_hi = $signed(sample) >= $signed(q.sh_lvl0[DATA_W-1:0]);
  assign trig_le = $signed(sample) <= $signed(q.sh_lvl0[DATA_W-1:0]);
  assign arm_hi  = $signed(sample) >= $signed(q.sh_lvl1[DATA_W-1:0]);

  // Crossings against the registered relation of the previous sample.
  assign up_trig = !q.prev_trig_hi && trig_hi;
  assign dn_trig = q.prev_trig_hi && !trig_hi;
  assign up_arm  = !q.prev_arm_hi && arm_hi;
  assign dn_arm  = q.prev_arm_hi && !arm_hi;

  // Decoding of the latched mode code.
  assign m_pos  = (q.sh_mode == `MODE_RISING_EDGE);
  assign m_neg  = (q.sh_mode == `MODE_FALLING_EDGE);
  assign m_high = (q.sh_mode == `MODE_HIGH_LEVEL);
  assign m_low  = (q.sh_mode == `MODE_LOW_LEVEL);
  assign m_rpos = (q.sh_mode == (`MODE_REARM_FLAG | `MODE_RISING_EDGE));
  assign m_rneg = (q.sh_mode == (`MODE_REARM_FLAG | `MODE_FALLING_EDGE))
               || (q.sh_mode == `MODE_REARM_NEG_ALT);
  assign running = (q.acq == ST_RUN);

  always_comb begin
    d = q;
    d.hreadyout = 1'b1;
    d.hresp = 1'b0;
    if (q.wr_pend) begin
      case (q.wr_idx)
        `IDX_OR_MASK:      d.or_mask = hwdata;
        `IDX_MODE:         d.mode = hwdata;
        `IDX_LEVEL:        d.lvl0 = hwdata;
        `IDX_SECOND_LEVEL: d.lvl1 = hwdata;
        `IDX_CONTROL:      d.run = hwdata[`CTRL_RUN_BIT];
        default:           d.run = q.run;
      endcase
    end
    d.wr_pend = acc && hwrite;
    d.wr_idx = haddr[31:2];
    case (q.acq)
      ST_IDLE: begin
        d.gate = 1'b0;
        d.armed = 1'b0;
        if (q.run) begin
          d.sh_mode = q.mode;
          d.sh_lvl0 = q.lvl0;
          d.sh_lvl1 = q.lvl1;
          d.sh_en = q.or_mask[`MASK_CH0_BIT];
          d.acq = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (sample_valid) begin
          d.prev_trig_hi = trig_hi;
          d.prev_arm_hi = arm_hi;
          if (m_high) begin
            d.gate = trig_hi;
          end else if (m_low) begin
            d.gate = trig_le;
          end else begin
            d.gate = 1'b0;
          end
          d.acq = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sample_valid) begin
          d.prev_trig_hi = trig_hi;
          d.prev_arm_hi = arm_hi;
          if (m_high) begin
            d.gate = trig_hi;
          end else if (m_low) begin
            d.gate = trig_le;
          end else if (m_pos) begin
            if (up_trig) begin
              d.gate = 1'b1;
            end else if (dn_trig) begin
              d.gate = 1'b0;
            end
          end else if (m_neg) begin
            if (dn_trig) begin
              d.gate = 1'b1;
            end else if (up_trig) begin
              d.gate = 1'b0;
            end
          end else if (m_rpos) begin
            if (q.armed && up_trig) begin
              d.gate = 1'b1;
            end else if (dn_trig) begin
              d.gate = 1'b0;
            end
            d.armed = (q.armed && !up_trig) || up_arm;
          end else if (m_rneg) begin
            if (q.armed && dn_trig) begin
              d.gate = 1'b1;
            end else if (up_trig) begin
              d.gate = 1'b0;
            end
            d.armed = (q.armed && !dn_trig) || dn_arm;
          end else begin
            d.gate = 1'b0;
          end
        end
      end
      default: begin
        d.acq = ST_IDLE;
      end
    endcase
    if (!q.sh_en) begin
      d.gate = 1'b0;
    end
    if (!q.run) begin
      d.acq = ST_IDLE;
      d.gate = 1'b0;
      d.armed = 1'b0;
    end
    if (acc && !hwrite) begin
      d.hrdata = read_word(d, haddr[31:2]);
    end else begin
      d.hrdata = `RESET_WORD;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign hrdata    = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp     = q.hresp;
  assign gate      = q.gate;
  assign armed     = q.armed;

  // A sample evaluated by the running engine.
  sequence s_eval;
    running && sample_valid && q.sh_en;
  endsequence

  // Two consecutive cycles with an acquisition under way.
  sequence s_active2;
    (q.acq != ST_IDLE) ##1 (q.acq != ST_IDLE);
  endsequence

  // An armed re-arm rising engine seeing its trigger crossing.
  sequence s_rpos_fire;
    s_eval ##0 (m_rpos && q.armed && up_trig && !up_arm);
  endsequence

  // An armed re-arm falling engine seeing its trigger crossing.
  sequence s_rneg_fire;
    s_eval ##0 (m_rneg && q.armed && dn_trig && !dn_arm);
  endsequence

  AST_MASK_BLOCKS: assert property (
    @(posedge clk) disable iff (!rst_b)
    (q.acq != ST_IDLE && !q.sh_en) |=> (!q.gate)[*2])
    else $error("Gate opened with the channel masked out.");

  AST_PREV_TRACKS: assert property (
    @(posedge clk) disable iff (!rst_b)
    (running && sample_valid && q.run) |=>
      (q.prev_trig_hi == $past(trig_hi)) && (q.prev_arm_hi == $past(arm_hi)))
    else $error("Previous sample relation not updated.");

  AST_POS_OPEN: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (m_pos && up_trig && q.run) |=> q.gate)
    else $error("Rising edge did not open the gate.");

  AST_POS_CLOSE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (m_pos && dn_trig) |=> !q.gate)
    else $error("Falling crossing did not close the gate.");

  AST_EDGE_NO_START: assert property (
    @(posedge clk) disable iff (!rst_b)
    (q.acq == ST_FIRST && sample_valid && (m_pos || m_neg)) |=> !q.gate)
    else $error("Edge mode opened without a crossing.");

  AST_HIGH_LEVEL: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (m_high && q.run) |=> (q.gate == $past(trig_hi)))
    else $error("High level gate does not follow the sample.");

  AST_LEVEL_START: assert property (
    @(posedge clk) disable iff (!rst_b)
    (q.acq == ST_FIRST && sample_valid && q.sh_en && q.run &&
     ((m_high && trig_hi) || (m_low && trig_le))) |=> q.gate)
    else $error("Level present at start did not open the gate.");

  AST_NEG_EDGE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (m_neg && q.run && (dn_trig || up_trig)) |=>
      (q.gate == $past(dn_trig)))
    else $error("Falling edge mode gate wrong after crossing.");

  AST_LOW_LEVEL: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (m_low && q.run) |=> (q.gate == $past(trig_le)))
    else $error("Low level gate does not follow the sample.");

  AST_REARM_POS_ARM: assert property (
    @(posedge clk) disable iff (!rst_b)
    (running && sample_valid && q.run && m_rpos && up_arm) |=> q.armed)
    else $error("Upward re-arm crossing did not arm.");

  AST_REARM_POS_FIRE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_rpos_fire ##0 q.run |=> (q.gate && !q.armed))
    else $error("Armed rising crossing did not fire and disarm.");

  AST_REARM_POS_CLOSE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (m_rpos && dn_trig) |=> !q.gate)
    else $error("Re-arm rising mode did not close the gate.");

  AST_DISARMED_IGNORES: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (!q.armed && q.run &&
                ((m_rpos && up_trig) || (m_rneg && dn_trig))) |=>
      $stable(q.gate))
    else $error("Disarmed engine reacted to a trigger crossing.");

  AST_REARM_NEG_ARM: assert property (
    @(posedge clk) disable iff (!rst_b)
    (running && sample_valid && q.run && m_rneg && dn_arm) |=> q.armed)
    else $error("Downward re-arm crossing did not arm.");

  AST_REARM_NEG_FIRE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_rneg_fire ##0 q.run |=> (q.gate && !q.armed))
    else $error("Armed falling crossing did not fire and disarm.");

  AST_CONFIG_HELD: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_active2 |-> ($stable(q.sh_mode) && $stable(q.sh_lvl0) &&
                   $stable(q.sh_lvl1) && $stable(q.sh_en)))
    else $error("Configuration changed during an acquisition.");

  AST_NO_SAMPLE_HOLD: assert property (
    @(posedge clk) disable iff (!rst_b)
    (running && !sample_valid && q.run) |=>
      ($stable(q.gate) && $stable(q.armed)))
    else $error("Gate or armed moved without a sample.");

  AST_REARM_NEG_CLOSE: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_eval ##0 (m_rneg && up_trig) |=> !q.gate)
    else $error("Re-arm falling mode did not close the gate.");

endmodule : channel_gate_trigger

// *** tb/adc_stream_model.sv ***
// Converter sample stream model for one channel.
`timescale 1ns/1ps
module adc_stream_model #(
  parameter int DW = 16
) (
  input  wire logic     clk,
  output logic [DW-1:0] sample,
  output logic          sample_valid
);
  initial begin
    sample       = '0;
    sample_valid = 1'b0;
  end
  // One sample for one cycle, then a scrambled bus for gap plus one cycles.
  task automatic send(input logic [DW-1:0] v, input int gap);
    @(posedge clk);
    sample       <= v;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample       <= ~v;
    sample_valid <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask : send
endmodule : adc_stream_model

// *** tb/tb_channel_gate_trigger.sv ***
// Self-checking bench for the channel gate trigger.
`timescale 1ns/1ps
`include "channel_gate_trigger_regs.svh"
module tb_channel_gate_trigger;
  import channel_gate_trigger_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        hsel;
  word_t       haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  word_t       hwdata;
  word_t       hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] sample;
  logic        sample_valid;
  logic        gate;
  logic        armed;
  word_t       rd;
  logic        rsp;
  int          mismatches;
  int          total_checks;
  logic [29:0] regs [4];
  word_t       nm [2];

  channel_gate_trigger #(.DATA_W(16)) i_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample(sample), .sample_valid(sample_valid),
    .gate(gate), .armed(armed)
  );

  adc_stream_model #(.DW(16)) i_adc (
    .clk(clk), .sample(sample), .sample_valid(sample_valid)
  );

  always #5 clk = ~clk;

  task automatic finish_test;
    $display("mismatches %0d checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic fail(input string m);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail

  task automatic bus_wait;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail("bus wait timed out");
        finish_test();
      end
      @(posedge clk);
    end
  endtask : bus_wait

  task automatic xfer(input logic [29:0] idx, input logic w, input word_t d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= `HSIZE_WORD;
    bus_wait();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
    rsp = hresp;
  endtask : xfer

  task automatic wr(input logic [29:0] idx, input word_t d);
    xfer(idx, 1'b1, d);
    total_checks++;
    if (rsp !== 1'b0) begin
      fail("error response on write");
    end
  endtask : wr

  task automatic chk(input logic [29:0] idx, input word_t e);
    xfer(idx, 1'b0, '0);
    total_checks++;
    if (rd !== e || rsp !== 1'b0) begin
      fail("register read mismatch");
    end
  endtask : chk

  task automatic start(input word_t m, input word_t l0, input word_t l1,
                       input logic en);
    wr(`IDX_CONTROL, '0);
    wr(`IDX_OR_MASK, {31'h0, en});
    wr(`IDX_MODE, m);
    wr(`IDX_LEVEL, l0);
    wr(`IDX_SECOND_LEVEL, l1);
    wr(`IDX_CONTROL, 32'h0000_0001);
  endtask : start

  task automatic smp(input int v, input logic eg, input logic ea,
                     input int gap);
    i_adc.send(v[15:0], gap);
    #1;
    total_checks++;
    if (gate !== eg || armed !== ea) begin
      fail("gate or armed mismatch");
    end
  endtask : smp

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `HSIZE_WORD;
    hwdata = '0;
    mismatches = 0;
    total_checks = 0;
    regs = '{`IDX_OR_MASK, `IDX_MODE, `IDX_LEVEL, `IDX_SECOND_LEVEL};
    nm = '{`MODE_REARM_FLAG | `MODE_FALLING_EDGE, `MODE_REARM_NEG_ALT};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk(regs[i], '0);
      wr(regs[i], 32'h0000_1230 + i);
      chk(regs[i], 32'h0000_1230 + i);
    end
    wr(30'h0000_0123, 32'hFFFF_FFFF);
    chk(30'h0000_0123, '0);
    $display("test registers done");
    start(`MODE_RISING_EDGE, '0, '0, 1'b1);
    smp(10, 0, 0, 0);
    smp(20, 0, 0, 3);
    smp(-5, 0, 0, 0);
    smp(0, 1, 0, 0);
    smp(5, 1, 0, 2);
    smp(-1, 0, 0, 0);
    smp(3, 1, 0, 0);
    chk(`IDX_STATUS, 32'h0000_0005);
    wr(`IDX_CONTROL, '0);
    chk(`IDX_STATUS, '0);
    start(`MODE_RISING_EDGE, '0, '0, 1'b0);
    smp(-5, 0, 0, 0);
    smp(5, 0, 0, 0);
    $display("test edge and mask done");
    start(`MODE_HIGH_LEVEL, '0, '0, 1'b1);
    smp(7, 1, 0, 0);
    smp(0, 1, 0, 0);
    wr(`IDX_LEVEL, 32'h0000_0064);
    smp(50, 1, 0, 0);
    smp(-1, 0, 0, 0);
    smp(3, 1, 0, 0);
    start(`MODE_FALLING_EDGE, '0, '0, 1'b1);
    smp(-5, 0, 0, 0);
    smp(5, 0, 0, 0);
    smp(-1, 1, 0, 0);
    smp(-3, 1, 0, 1);
    smp(0, 0, 0, 0);
    start(`MODE_LOW_LEVEL, '0, '0, 1'b1);
    smp(-2, 1, 0, 0);
    smp(0, 1, 0, 0);
    smp(1, 0, 0, 0);
    smp(-8, 1, 0, 0);
    start(32'h0000_0004, '0, '0, 1'b1);
    smp(-5, 0, 0, 0);
    smp(5, 0, 0, 0);
    $display("test level modes done");
    start(`MODE_REARM_FLAG | `MODE_RISING_EDGE, 32'h0000_0064, '0, 1'b1);
    smp(-50, 0, 0, 0);
    smp(50, 0, 1, 0);
    smp(150, 1, 0, 0);
    smp(50, 0, 0, 0);
    smp(150, 0, 0, 0);
    smp(-50, 0, 0, 0);
    smp(50, 0, 1, 0);
    chk(`IDX_STATUS, 32'h0000_0006);
    smp(150, 1, 0, 0);
    for (int i = 0; i < 2; i++) begin
      start(nm[i], 32'hFFFF_FF9C, '0, 1'b1);
      smp(50, 0, 0, 0);
      smp(-50, 0, 1, 0);
      smp(-150, 1, 0, 0);
      smp(-50, 0, 0, 0);
      smp(-150, 0, 0, 0);
    end
    $display("test re-arm modes done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk(`IDX_MODE, '0);
    chk(`IDX_STATUS, '0);
    $display("test reset done");
    finish_test();
  end
endmodule : tb_channel_gate_trigger
